// ===== core/dual_timer.sv
// dual 8051-style counter/timer with split mode
`timescale 1ns/1ps
module dual_timer (
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   // special function register bus
   input  wire timer_pkg::sfr_write_type sfr_write,
   input  wire logic [7:0]              sfr_read_addr,
   output logic [7:0]                   sfr_rdata,
   // interrupt vectoring acknowledge from the core
   input  wire timer_pkg::vector_ack_type vector_ack,
   // board pins
   input  wire logic                    timer0_count_pin,
   input  wire logic                    timer1_count_pin,
   input  wire logic                    ext_irq_zero_input_n,
   input  wire logic                    ext_irq_one_input_n,
   input  wire logic                    ext_clock,
   // events
   output logic                         timer1_overflow_pulse,
   output logic                         timer0_irq,
   output logic                         timer1_irq,
   output logic                         ext_irq_zero,
   output logic                         ext_irq_one
);
   import timer_pkg::*;

   logic [7:0] timer_control_status;
   logic [7:0] timer_mode_select;
   logic [7:0] timer_clock_select;
   logic [7:0] timer0_count_low;
   logic [7:0] timer0_count_high;
   logic [7:0] timer1_count_low;
   logic [7:0] timer1_count_high;

   // write decode shared by every register
   function automatic logic wr_hit(input sfr_write_type w, input logic [7:0] a);
      wr_hit = w.wr && (w.addr == a);
   endfunction

   // two-stage synchronisers: pins and the external clock divider bit
   logic [1:0] sync_t0;
   logic [1:0] sync_t1;
   logic [1:0] sync_i0;
   logic [1:0] sync_i1;
   logic [1:0] sync_ext;
   logic       prev_t0;
   logic       prev_t1;
   logic       prev_i0;
   logic       prev_ext;
   logic       prev_i1;
   logic [2:0] ext_div;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync_t0  <= 2'h3;
         sync_t1  <= 2'h3;
         sync_i0  <= 2'h3;
         sync_i1  <= 2'h3;
         sync_ext <= 2'h0;
         prev_t0  <= 1'b1;
         prev_t1  <= 1'b1;
         prev_i0  <= 1'b1;
         prev_i1  <= 1'b1;
         prev_ext <= 1'b0;
      end else begin
         sync_t0  <= {sync_t0[0], timer0_count_pin};
         sync_t1  <= {sync_t1[0], timer1_count_pin};
         sync_i0  <= {sync_i0[0], ext_irq_zero_input_n};
         sync_i1  <= {sync_i1[0], ext_irq_one_input_n};
         sync_ext <= {sync_ext[0], ext_div[2]};
         prev_t0  <= sync_t0[1];
         prev_t1  <= sync_t1[1];
         prev_i0  <= sync_i0[1];
         prev_i1  <= sync_i1[1];
         prev_ext <= sync_ext[1];
      end
   end

   // external clock divided by 8 in its own domain; only its msb crosses
   always_ff @(posedge ext_clock or negedge rstn) begin
      if (!rstn) begin
         ext_div <= 3'h0;
      end else begin
         ext_div <= ext_div + 3'h1;
      end
   end

   // falling edges of pins; pin source must hold levels two clocks
   logic fall_t0;
   logic fall_t1;
   logic fall_i0;
   logic fall_i1;
   logic ext_tick;
   assign fall_t0  = prev_t0 & ~sync_t0[1];
   assign fall_t1  = prev_t1 & ~sync_t1[1];
   assign fall_i0  = prev_i0 & ~sync_i0[1];
   assign fall_i1  = prev_i1 & ~sync_i1[1];
   assign ext_tick = sync_ext[1] & ~prev_ext;

   // system clock prescaler
   // a smaller new divisor only shortens the period in flight, the count never sticks above it
   logic [5:0] pre_count;
   logic [5:0] pre_last;
   logic       pre_tick;
   logic       scaled_tick;

   always_comb begin
      case (timer_clock_select[1:0])
         2'h0:    pre_last = div_12_last;
         2'h1:    pre_last = div_4_last;
         2'h2:    pre_last = div_48_last;
         default: pre_last = div_12_last;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pre_count <= 6'h00;
      end else if (pre_count >= pre_last) begin
         pre_count <= 6'h00;
      end else begin
         pre_count <= pre_count + 6'h01;
      end
   end

   assign pre_tick    = (pre_count >= pre_last);
   assign scaled_tick = (timer_clock_select[1:0] == 2'h3) ? ext_tick : pre_tick;

   // timer clock selection; clock choice is ignored in counter mode
   function automatic logic pick_tick(input logic counter_sel, input logic sys_choice,
                                      input logic pin_fall, input logic scaled);
      if (counter_sel) begin
         pick_tick = pin_fall;
      end else begin
         pick_tick = sys_choice ? 1'b1 : scaled;
      end
   endfunction

   logic [1:0] t0_mode;
   logic [1:0] t1_mode;
   logic       split;
   logic       t0_enable;
   logic       t1_enable;
   logic       t0_tick;
   logic       t1_tick;
   logic       th0_tick;
   assign t0_mode = timer_mode_select[1:0];
   assign t1_mode = timer_mode_select[5:4];
   assign split   = (t0_mode == mode_split);

   // run bit alone, or run bit and input high when gated; timer 1 never runs in mode 3
   // split timer 1 keeps running so its overflow pulse still paces the serial logic
   assign t0_enable = timer_control_status[bit_tr0] &
                      (~timer_mode_select[bit_timer0_pin_gating] | sync_i0[1]);
   assign t1_enable = split ? (t1_mode != mode_split)
                    : (timer_control_status[bit_tr1] & (t1_mode != mode_split) &
                       (~timer_mode_select[bit_timer1_pin_gating] | sync_i1[1]));

   assign t0_tick  = t0_enable & pick_tick(timer_mode_select[bit_ct0], timer_clock_select[bit_t0m],
                                          fall_t0, scaled_tick);
   assign t1_tick  = t1_enable & pick_tick(timer_mode_select[bit_ct1] & ~split,
                                          timer_clock_select[bit_t1m], fall_t1, scaled_tick);
   // high byte of split timer 0 times only, on timer 1 run and timer 0 clock choice
   assign th0_tick = split & timer_control_status[bit_tr1] &
                     pick_tick(1'b0, timer_clock_select[bit_t0m], 1'b0, scaled_tick);

   // next counts and overflow per mode
   logic [7:0] next_t0_low;
   logic [7:0] next_t0_high;
   logic [7:0] next_t1_low;
   logic [7:0] next_t1_high;
   logic       t0_ovf;
   logic       t1_ovf;
   logic       th0_ovf;

   task automatic step(input logic [1:0] mode, input logic [7:0] low, input logic [7:0] high,
                       output logic [7:0] nlow, output logic [7:0] nhigh, output logic ovf);
      logic [15:0] wide;
      wide  = 16'h0000;
      nlow  = low;
      nhigh = high;
      ovf   = 1'b0;
      case (mode)
         mode_13bit: begin
            wide  = {high, low[4:0], 3'h0} + 16'h0008;
            nhigh = wide[15:8];
            nlow  = {low[7:5], wide[7:3]};
            ovf   = ({high, low[4:0]} == 13'h1fff);
         end
         mode_16bit: begin
            wide  = {high, low} + 16'h0001;
            nhigh = wide[15:8];
            nlow  = wide[7:0];
            ovf   = ({high, low} == 16'hffff);
         end
         default: begin
            ovf  = (low == 8'hff);
            nlow = ovf ? high : low + 8'h01;
         end
      endcase
   endtask

   always_comb begin
      next_t0_low  = timer0_count_low;
      next_t0_high = timer0_count_high;
      next_t1_low  = timer1_count_low;
      next_t1_high = timer1_count_high;
      t0_ovf       = 1'b0;
      t1_ovf       = 1'b0;
      th0_ovf      = 1'b0;
      if (split) begin
         if (t0_tick) begin
            t0_ovf      = (timer0_count_low == 8'hff);
            next_t0_low = timer0_count_low + 8'h01;
         end
         if (th0_tick) begin
            th0_ovf      = (timer0_count_high == 8'hff);
            next_t0_high = timer0_count_high + 8'h01;
         end
      end else if (t0_tick) begin
         step(t0_mode, timer0_count_low, timer0_count_high, next_t0_low, next_t0_high, t0_ovf);
      end
      if (t1_tick) begin
         step(t1_mode, timer1_count_low, timer1_count_high, next_t1_low, next_t1_high, t1_ovf);
      end
   end

   // counters: software writes win over counting; run bit never reloads
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer0_count_low  <= reset_byte;
         timer0_count_high <= reset_byte;
         timer1_count_low  <= reset_byte;
         timer1_count_high <= reset_byte;
      end else begin
         timer0_count_low  <= wr_hit(sfr_write, addr_t0_low) ? sfr_write.wdata
                            : next_t0_low;
         timer0_count_high <= wr_hit(sfr_write, addr_t0_high) ? sfr_write.wdata
                            : next_t0_high;
         timer1_count_low  <= wr_hit(sfr_write, addr_t1_low) ? sfr_write.wdata
                            : next_t1_low;
         timer1_count_high <= wr_hit(sfr_write, addr_t1_high) ? sfr_write.wdata
                            : next_t1_high;
      end
   end

   // timer 1 flag comes from the high byte while split
   // level mode sets every cycle the pin is low; a software clear sticks only once it is high
   logic set_tf1;
   logic set_ie0;
   logic set_ie1;
   assign set_tf1 = split ? th0_ovf : t1_ovf;
   assign set_ie0 = timer_control_status[bit_it0] ? fall_i0 : ~sync_i0[1];
   assign set_ie1 = timer_control_status[bit_it1] ? fall_i1 : ~sync_i1[1];

   // flag update: hardware set wins over software or vector clear
   function automatic logic flag_next(input logic cur, input logic wr, input logic wbit,
                                      input logic clr, input logic set);
      logic v;
      v = wr ? wbit : cur;
      if (clr) begin
         v = 1'b0;
      end
      flag_next = v | set;
   endfunction

   logic       ctrl_wr;
   logic [7:0] wd;
   assign ctrl_wr = wr_hit(sfr_write, addr_control);
   assign wd      = sfr_write.wdata;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer_control_status <= reset_byte;
      end else begin
         timer_control_status[bit_tf1] <= flag_next(timer_control_status[bit_tf1], ctrl_wr, wd[bit_tf1],
                                                    vector_ack.timer1, set_tf1);
         timer_control_status[bit_tf0] <= flag_next(timer_control_status[bit_tf0], ctrl_wr, wd[bit_tf0],
                                                    vector_ack.timer0, t0_ovf);
         timer_control_status[bit_ie1] <= flag_next(timer_control_status[bit_ie1], ctrl_wr, wd[bit_ie1],
                                                    vector_ack.ext1 & timer_control_status[bit_it1],
                                                    set_ie1);
         timer_control_status[bit_ie0] <= flag_next(timer_control_status[bit_ie0], ctrl_wr, wd[bit_ie0],
                                                    vector_ack.ext0 & timer_control_status[bit_it0],
                                                    set_ie0);
         if (ctrl_wr) begin
            timer_control_status[bit_tr1] <= wd[bit_tr1];
            timer_control_status[bit_tr0] <= wd[bit_tr0];
            timer_control_status[bit_it1] <= wd[bit_it1];
            timer_control_status[bit_it0] <= wd[bit_it0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer_mode_select <= reset_byte;
      end else if (wr_hit(sfr_write, addr_mode)) begin
         timer_mode_select <= sfr_write.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timer_clock_select <= reset_byte;
      end else if (wr_hit(sfr_write, addr_clock)) begin
         timer_clock_select <= sfr_write.wdata & clock_mask;
      end
   end

   // register read mux and event outputs, all from flip-flops
   // read data costs one cycle but leaves no combinational path back to the core
   logic [7:0] next_rdata;
   always_comb begin
      case (sfr_read_addr)
         addr_control: next_rdata = timer_control_status;
         addr_mode:    next_rdata = timer_mode_select;
         addr_t0_low:  next_rdata = timer0_count_low;
         addr_t1_low:  next_rdata = timer1_count_low;
         addr_t0_high: next_rdata = timer0_count_high;
         addr_t1_high: next_rdata = timer1_count_high;
         addr_clock:   next_rdata = timer_clock_select & clock_mask;
         default:      next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata             <= 8'h00;
         timer1_overflow_pulse <= 1'b0;
      end else begin
         sfr_rdata             <= next_rdata;
         timer1_overflow_pulse <= t1_ovf;
      end
   end

   assign timer0_irq   = timer_control_status[bit_tf0];
   assign timer1_irq   = timer_control_status[bit_tf1];
   assign ext_irq_zero = timer_control_status[bit_ie0];
   assign ext_irq_one  = timer_control_status[bit_ie1];
endmodule

// ===== core/timer_pkg.sv
// constants and types for the dual counter/timer block
package timer_pkg;
   localparam logic [7:0] addr_control  = 8'h88;
   localparam logic [7:0] addr_mode     = 8'h89;
   localparam logic [7:0] addr_t0_low   = 8'h8a;
   localparam logic [7:0] addr_t1_low   = 8'h8b;
   localparam logic [7:0] addr_t0_high  = 8'h8c;
   localparam logic [7:0] addr_t1_high  = 8'h8d;
   localparam logic [7:0] addr_clock    = 8'h8e;
   localparam logic [7:0] reset_byte    = 8'h00;
   localparam logic [7:0] clock_mask    = 8'h1b;
   localparam int bit_tf1 = 7;
   localparam int bit_tr1 = 6;
   localparam int bit_tf0 = 5;
   localparam int bit_tr0 = 4;
   localparam int bit_ie1 = 3;
   localparam int bit_it1 = 2;
   localparam int bit_ie0 = 1;
   localparam int bit_it0 = 0;
   localparam int bit_timer1_pin_gating = 7;
   localparam int bit_ct1   = 6;
   localparam int bit_timer0_pin_gating = 3;
   localparam int bit_ct0   = 2;
   localparam int bit_t1m   = 4;
   localparam int bit_t0m   = 3;
   localparam logic [1:0] mode_13bit  = 2'h0;
   localparam logic [1:0] mode_16bit  = 2'h1;
   localparam logic [1:0] mode_reload = 2'h2;
   localparam logic [1:0] mode_split  = 2'h3;
   localparam logic [5:0] div_12_last  = 6'h0b;
   localparam logic [5:0] div_4_last   = 6'h03;
   localparam logic [5:0] div_48_last  = 6'h2f;
   localparam logic [2:0] ext_div_last = 3'h7;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_write_type;

   typedef struct packed {
      logic timer0;
      logic timer1;
      logic ext0;
      logic ext1;
   } vector_ack_type;
endpackage

// ===== tb/dual_timer_assertions.sv
// port-level checks for the dual counter/timer
`timescale 1ns/1ps
module dual_timer_assertions (
   // clock and reset
   input wire logic                      clk_sys,
   input wire logic                      rstn,
   // register bus and vectoring
   input wire timer_pkg::sfr_write_type  sfr_write,
   input wire logic [7:0]                sfr_read_addr,
   input wire logic [7:0]                sfr_rdata,
   input wire timer_pkg::vector_ack_type vector_ack,
   // pins and events
   input wire logic                      ext_irq_zero_input_n,
   input wire logic                      ext_irq_one_input_n,
   input wire logic                      timer1_overflow_pulse,
   input wire logic                      timer0_irq,
   input wire logic                      timer1_irq,
   input wire logic                      ext_irq_zero,
   input wire logic                      ext_irq_one
);
   import timer_pkg::*;
   // shadows of whole written bytes; only software-owned bits are used, flags are hardware-owned
   logic       ctl_wr;
   logic [7:0] ctl_q;
   logic [7:0] mode_q;
   assign ctl_wr = sfr_write.wr && sfr_write.addr == addr_control;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctl_q <= 8'h00;
      end else if (ctl_wr) begin
         ctl_q <= sfr_write.wdata;
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mode_q <= 8'h00;
      end else if (sfr_write.wr && sfr_write.addr == addr_mode) begin
         mode_q <= sfr_write.wdata;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_clock_unused;
      sfr_read_addr == addr_clock |=> (sfr_rdata & 8'he4) == 8'h00;
   endproperty
   a_clock_unused: assert property (p_clock_unused) else $error("unused clock select bits read nonzero");
   property p_ext1_vector;
      ext_irq_one_input_n [*6] ##0 (vector_ack.ext1 && ctl_q[bit_it1] && !ctl_wr) |=> !ext_irq_one;
   endproperty
   a_ext1_vector: assert property (p_ext1_vector) else $error("edge flag not cleared by vectoring");
   property p_ext0_level;
      (!ext_irq_zero_input_n && !ctl_q[bit_it0]) [*8] |-> ext_irq_zero;
   endproperty
   a_ext0_level: assert property (p_ext0_level) else $error("low level did not set flag");
   property p_tf0_vector;
      vector_ack.timer0 && !ctl_q[bit_tr0] && !ctl_wr |=> !timer0_irq;
   endproperty
   a_tf0_vector: assert property (p_tf0_vector) else $error("timer0 flag kept after vectoring");
   property p_tf1_vector;
      vector_ack.timer1 && !ctl_q[bit_tr1] && !ctl_wr |=> !timer1_irq;
   endproperty
   a_tf1_vector: assert property (p_tf1_vector) else $error("timer1 flag kept after vectoring");
   property p_run_off_holds;
      (!ctl_q[bit_tr0] && sfr_read_addr == addr_t0_low && !sfr_write.wr) [*4] |-> $stable(sfr_rdata);
   endproperty
   a_run_off_holds: assert property (p_run_off_holds) else $error("timer0 low byte moved while stopped");
   property p_t1_inactive;
      (mode_q[5:4] == mode_split && sfr_read_addr == addr_t1_low && !sfr_write.wr) [*4] |-> $stable(sfr_rdata);
   endproperty
   a_t1_inactive: assert property (p_t1_inactive) else $error("timer1 counted in mode 3");
   property p_split_no_tf1;
      mode_q[1:0] == mode_split && !ctl_q[bit_tr1] && !ctl_wr && !timer1_irq |=> !timer1_irq;
   endproperty
   a_split_no_tf1: assert property (p_split_no_tf1) else $error("timer1 flag set while split and idle");
   c_pulse: cover property (timer1_overflow_pulse);
   c_ext1_ack: cover property (vector_ack.ext1 && ext_irq_one);
   c_split_flag: cover property (mode_q[1:0] == mode_split && $rose(timer1_irq));
endmodule

// ===== tb/sfr_core_model.sv
// processor core side: register bus cycles and interrupt vectoring
`timescale 1ns/1ps
module sfr_core_model (
   // clock
   input  wire logic               clk_sys,
   // register bus
   output timer_pkg::sfr_write_type sfr_write,
   output logic [7:0]              sfr_read_addr,
   input  wire logic [7:0]         sfr_rdata,
   // vectoring
   output timer_pkg::vector_ack_type vector_ack
);
   import timer_pkg::*;
   initial begin
      sfr_write = '0;
      sfr_read_addr = 8'h00;
      vector_ack = '0;
   end
   // one-cycle strobe; a gap edge lets back-to-back writes never merge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_write <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys);
      sfr_write <= '0;
   endtask
   // address stays put afterwards, read data is registered
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      sfr_read_addr <= a;
      repeat (2) @(posedge clk_sys);
      d = sfr_rdata;
   endtask
   task automatic vector_to(input vector_ack_type v);
      @(posedge clk_sys);
      vector_ack <= v;
      @(posedge clk_sys);
      vector_ack <= '0;
   endtask
endmodule

// ===== tb/dual_timer_tb_top.sv
// self-checking bench for the dual counter/timer
`timescale 1ns/1ps
module dual_timer_tb_top;
   import timer_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
   logic clk_sys, rstn, t0_pin, t1_pin, irq0_n, irq1_n, ext_clock;
   logic [7:0] rdata, v, rdata_hold;
   logic t1_pulse, t0_irq, t1_irq, x0_irq, x1_irq;
   sfr_write_type wr_bus;
   vector_ack_type ack;
   logic [7:0] raddr;
   int err_total, n_tests, t1, t2;
   int cyc = 0;
   row_type rows[7] = '{'{addr_mode, 8'ha5, 8'ha5}, '{addr_t0_low, 8'h3c, 8'h3c}, '{addr_t1_low, 8'hc3, 8'hc3},
      '{addr_t0_high, 8'h5a, 8'h5a}, '{addr_t1_high, 8'h96, 8'h96}, '{addr_clock, 8'hff, 8'h1b}, '{8'h8f, 8'h77, 8'h00}};
   row_type scale[5] = '{'{8'h08, 8'h00, 8'h04}, '{8'h01, 8'h00, 8'h10}, '{8'h00, 8'h00, 8'h30},
      '{8'h02, 8'h00, 8'hc0}, '{8'h03, 8'h00, 8'h28}};
   row_type wraps[3] = '{'{8'h00, 8'hff, 8'he0}, '{8'h01, 8'hff, 8'h00}, '{8'h02, 8'ha5, 8'ha5}};
   sfr_core_model core_u (.clk_sys(clk_sys), .sfr_write(wr_bus), .sfr_read_addr(raddr), .sfr_rdata(rdata),
      .vector_ack(ack));
   dual_timer dut_u (.clk_sys(clk_sys), .rstn(rstn), .sfr_write(wr_bus), .sfr_read_addr(raddr), .sfr_rdata(rdata),
      .vector_ack(ack), .timer0_count_pin(t0_pin), .timer1_count_pin(t1_pin), .ext_irq_zero_input_n(irq0_n),
      .ext_irq_one_input_n(irq1_n), .ext_clock(ext_clock), .timer1_overflow_pulse(t1_pulse), .timer0_irq(t0_irq),
      .timer1_irq(t1_irq), .ext_irq_zero(x0_irq), .ext_irq_one(x1_irq));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // free-running and slower than the system clock
   initial begin
      ext_clock = 1'b0;
      forever #5 ext_clock = ~ext_clock;
   end
   always_ff @(posedge clk_sys) cyc <= cyc + 1;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // bounded poll; which: 0 timer0 flag, 1 timer1 flag, 2 overflow pulse; running out is a mismatch
   task automatic wait_flag(input int which, output int t);
      int c;
      logic hit;
      c = 0;
      hit = 1'b0;
      while (!hit && c < 1000) begin
         @(posedge clk_sys);
         c++;
         hit = (which == 0) ? (t0_irq === 1'b1) : (which == 1) ? (t1_irq === 1'b1) : (t1_pulse === 1'b1);
      end
      if (!hit) begin
         err_total++;
      end
      t = cyc;
   endtask
   // each level held four clocks so every fall is sampled
   task automatic pulse_pin(input int n);
      repeat (n) begin
         t0_pin <= 1'b0;
         repeat (4) @(posedge clk_sys);
         t0_pin <= 1'b1;
         repeat (4) @(posedge clk_sys);
      end
   endtask
   initial begin
      {err_total, n_tests} = '0;
      {t0_pin, t1_pin, irq0_n, irq1_n} = 4'hf;
      rstn = 1'b0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         core_u.read_reg(rows[i].a, v);
         check("reset value", v, 8'h00);
      end
      foreach (rows[i]) begin
         core_u.write_reg(rows[i].a, rows[i].d);
         core_u.read_reg(rows[i].a, v);
         check("readback", v, rows[i].e);
      end
      core_u.write_reg(addr_mode, 8'h02);
      core_u.write_reg(addr_t0_low, 8'hfc);
      core_u.write_reg(addr_t0_high, 8'hfc);
      foreach (scale[i]) begin
         core_u.write_reg(addr_clock, scale[i].a);
         core_u.write_reg(addr_control, 8'h10);
         repeat (2) begin
            wait_flag(0, t1);
            core_u.vector_to('{timer0: 1'b1, default: 1'b0});
         end
         wait_flag(0, t2);
         check("tick period", 8'(t2 - t1), scale[i].e);
         core_u.write_reg(addr_control, 8'h00);
      end
      core_u.vector_to('{timer0: 1'b1, default: 1'b0});
      core_u.write_reg(addr_clock, 8'h02);
      foreach (wraps[i]) begin
         core_u.write_reg(addr_mode, wraps[i].a);
         core_u.write_reg(addr_t0_low, 8'hff);
         core_u.write_reg(addr_t0_high, wraps[i].d);
         core_u.write_reg(addr_control, 8'h10);
         wait_flag(0, t1);
         core_u.write_reg(addr_control, 8'h20);
         core_u.read_reg(addr_t0_low, v);
         check("low after wrap", v, wraps[i].e);
         core_u.read_reg(addr_t0_high, v);
         check("high after wrap", v, wraps[i].d == 8'ha5 ? 8'ha5 : 8'h00);
         core_u.vector_to('{timer0: 1'b1, default: 1'b0});
         @(posedge clk_sys);
         check("timer0 flag", 8'(t0_irq), 8'h00);
      end
      core_u.write_reg(addr_mode, 8'h0d);
      core_u.write_reg(addr_t0_low, 8'h00);
      irq0_n <= 1'b0;
      core_u.write_reg(addr_control, 8'h10);
      pulse_pin(3);
      core_u.read_reg(addr_t0_low, v);
      check("gated count", v, 8'h00);
      irq0_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pulse_pin(3);
      repeat (6) @(posedge clk_sys);
      core_u.read_reg(addr_t0_low, v);
      check("pin count", v, 8'h03);
      core_u.write_reg(addr_control, 8'h00);
      core_u.write_reg(addr_clock, 8'h18);
      core_u.write_reg(addr_t0_low, 8'h55);
      core_u.write_reg(addr_t0_high, 8'hf0);
      core_u.write_reg(addr_t1_low, 8'h1e);
      core_u.write_reg(addr_t1_high, 8'hf0);
      core_u.write_reg(addr_mode, 8'h23);
      core_u.write_reg(addr_control, 8'h40);
      wait_flag(1, t1);
      core_u.write_reg(addr_control, 8'h80);
      core_u.read_reg(addr_t0_low, v);
      check("split low byte", v, 8'h55);
      check("split high flag", 8'(t1_irq), 8'h01);
      core_u.vector_to('{timer1: 1'b1, default: 1'b0});
      wait_flag(2, t2);
      check("timer1 pulse", 8'(t1_pulse), 8'h01);
      check("timer1 flag", 8'(t1_irq), 8'h00);
      core_u.write_reg(addr_mode, 8'h33);
      core_u.read_reg(addr_t1_low, rdata_hold);
      repeat (30) @(posedge clk_sys);
      core_u.read_reg(addr_t1_low, v);
      check("timer1 idle", v, rdata_hold);
      core_u.write_reg(addr_control, 8'h04);
      irq1_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      irq1_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check("edge flag", 8'(x1_irq), 8'h01);
      core_u.vector_to('{ext1: 1'b1, default: 1'b0});
      @(posedge clk_sys);
      check("edge flag cleared", 8'(x1_irq), 8'h00);
      irq0_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      check("level flag", 8'(x0_irq), 8'h01);
      irq0_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      core_u.write_reg(addr_control, 8'h04);
      @(posedge clk_sys);
      check("level flag cleared", 8'(x0_irq), 8'h00);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      print_verdict();
   end
endmodule
bind dual_timer dual_timer_assertions chk_u (.clk_sys(clk_sys), .rstn(rstn), .sfr_write(sfr_write),
   .sfr_read_addr(sfr_read_addr), .sfr_rdata(sfr_rdata), .vector_ack(vector_ack),
   .ext_irq_zero_input_n(ext_irq_zero_input_n), .ext_irq_one_input_n(ext_irq_one_input_n),
   .timer1_overflow_pulse(timer1_overflow_pulse), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
   .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one));
